// ---- irq_ctrl_pkg.sv ----
// Package: register map, field positions and shared types of the interrupt controller
package irq_ctrl_pkg;

  // Register byte addresses (offsets are all multiples of four: index x4)
  localparam logic [7:0] OPTION_IDX = 8'hC8;
  localparam logic [7:0] POLARITY_IDX = 8'hDA;
  localparam logic [9:0] OPTION_ADDR = {OPTION_IDX, 2'b00};
  localparam logic [9:0] POLARITY_ADDR = {POLARITY_IDX, 2'b00};
  // Own control/status registers
  localparam logic [9:0] CORE_STATUS_ADDR = 10'h3E0;

  // Option register fields
  localparam int OPT_LEVEL_BIT = 6;
  localparam int OPT_EDGE_BIT = 5;
  localparam int OPT_ENABLE_BIT = 4;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] OPTION_WMASK = 8'h70;

  // Polarity register fields
  localparam int POL_PORTB_BIT = 0;
  localparam int POL_PORTA_BIT = 1;
  localparam int POL_PORTC_BIT = 2;
  localparam int POL_PORTD_BIT = 3;
  localparam int POL_PORTE_BIT = 4;
  localparam logic [7:0] POLARITY_RESET = 8'h00;
  localparam logic [7:0] POLARITY_WMASK = 8'h1F;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Peripheral event bundle with its enables
  typedef struct packed {
    logic timer_overflow_flag;
    logic timer_irq_enable;
    logic conversion_done_flag;
    logic converter_irq_enable;
    logic byte_received_flag;
    logic receive_irq_enable;
    logic byte_sent_flag;
    logic transmit_irq_enable;
  } src4_events_t;

  typedef struct packed {
    logic reload_timer_overflow_flag;
    logic reload_overflow_irq_enable;
    logic capture_one_flag;
    logic capture_one_irq_enable;
    logic capture_two_flag;
    logic capture_two_irq_enable;
    logic compare_zero_flag;
    logic compare_zero_irq_enable;
    logic compare_match_flag;
    logic compare_match_irq_enable;
  } src3_events_t;

  // Core handshake
  typedef struct packed {
    logic instr_end;      // Instruction boundary sample point
    logic return_from_irq_instr;
    logic in_stop_wait;   // Core sleeping in stop or wait
  } core_req_t;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_IRQ = 3'b010,
    MODE_NMI = 3'b100
  } core_mode_t;

endpackage : irq_ctrl_pkg

// ---- pin_sync.sv ----
// Two-flop synchroniser bank for port pin interrupt inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // Pins idle high; reset to inactive level so no edge at release
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;
endmodule : pin_sync

// ---- edge_latch.sv ----
// Edge or level request latch for one interrupt source line
`timescale 1ns/1ps
module edge_latch (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic line_in,      // Active-high request level
  input wire logic level_mode_in,
  input wire logic ack_in,       // Service routine start
  output logic req_out
);
  logic prev_r;
  logic pend_r;
  logic pend_nxt;
  wire rise = line_in & ~prev_r;

  // Set wins over a clear in the same cycle
  assign pend_nxt = level_mode_in ? 1'b0 : (rise | (pend_r & ~ack_in));

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      prev_r <= line_in;
      pend_r <= pend_nxt;
    end
  end

  // Level mode stores nothing; line sampled directly
  assign req_out = level_mode_in ? line_in : pend_r;
endmodule : edge_latch

// ---- irq_option_polarity_ctrl.sv ----
// Interrupt controller: option/polarity registers, source logic, vectoring
//
// Contract
// R01: On return-from-interrupt, restore prior flag set and reload PC from stack.
// R02: Option register is write-only; reads return no stored value; its bits 6..4 still read back in the status register.
// R03: Option register clears on reset; maskable interrupts disabled.
// R04: Level/edge bit set makes source 1 level, clear makes it edge.
// R05: Edge polarity bit chooses the triggering edge of source 2.
// R06: Global enable set enables all; clear disables all but non-maskable.
// R07: With global enable low, non-maskable serviced but wakes nothing.
// R08: Option bit 7 and bits 3..0 unused; writes ignored.
// R09: Timer, converter, receive, send events gated and ORed onto source 4.
// R10: Reload timer overflow, captures, zero, compare gated onto source 3.
// R11: Polarity register read/write; bits 4..0 ports E,D,C,A,B.
// R12: Polarity bit set inverts the port's interrupt sense.
// R13: Polarity register clears on reset.
// R14: Port C drives source 0; falling edge, rising when bit set.
// R15: Ports B, D drive source 2 edges; each set bit flips sense.
// R16: Ports A, E drive source 1; edge or level per option bit.
// R17: Edge sets latch, cleared at routine start; one extra edge kept.
// R18: Level requests not stored; sampled at instruction end.
// R19: Maskable served by fixed priority 1..4; no mutual pre-emption.
// R20: Non-maskable request latched, cleared when its routine begins.
// R21: Port pin inputs synchronised before edge detection.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module irq_option_polarity_ctrl #(
  parameter int PORT_WIDTH = 8,
  parameter int STACK_DEPTH = 6,
  parameter int PC_WIDTH = 12
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // AXI4-Lite slave
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port pins, active level chosen by polarity
  input wire logic [PORT_WIDTH-1:0] port_a_pins_in,
  input wire logic [PORT_WIDTH-1:0] port_b_pins_in,
  input wire logic [PORT_WIDTH-1:0] port_c_pins_in,
  input wire logic [PORT_WIDTH-1:0] port_d_pins_in,
  input wire logic [PORT_WIDTH-1:0] port_e_pins_in,
  input wire logic [PORT_WIDTH-1:0] port_a_irq_en_in,
  input wire logic [PORT_WIDTH-1:0] port_b_irq_en_in,
  input wire logic [PORT_WIDTH-1:0] port_c_irq_en_in,
  input wire logic [PORT_WIDTH-1:0] port_d_irq_en_in,
  input wire logic [PORT_WIDTH-1:0] port_e_irq_en_in,
  input wire logic spi_irq_in,
  // Peripheral events
  input wire irq_ctrl_pkg::src4_events_t src4_events_in,
  input wire irq_ctrl_pkg::src3_events_t src3_events_in,
  // Core side
  input wire irq_ctrl_pkg::core_req_t core_in,
  input wire logic [PC_WIDTH-1:0] core_pc_in,
  input wire logic [1:0] core_flags_in,
  output logic take_irq_out,
  output logic [2:0] irq_source_out,
  output logic [PC_WIDTH-1:0] vector_out,
  output logic irq_ret_out,
  output logic [PC_WIDTH-1:0] return_pc_out,
  output logic [1:0] restore_flags_out,
  output logic wake_out,
  output logic [2:0] core_mode_out
);
  import irq_ctrl_pkg::*;

  localparam int PTR_W = $clog2(STACK_DEPTH + 1);
  localparam logic [PC_WIDTH-1:0] VEC_SRC0 = 12'hFFC;
  localparam logic [PC_WIDTH-1:0] VEC_SRC1 = 12'hFF6;
  localparam logic [PC_WIDTH-1:0] VEC_SRC2 = 12'hFF4;
  localparam logic [PC_WIDTH-1:0] VEC_SRC3 = 12'hFF2;
  localparam logic [PC_WIDTH-1:0] VEC_SRC4 = 12'hFF0;

  // Any pin of a port with interrupt enabled at active-low level
  function automatic logic port_low(input logic [PORT_WIDTH-1:0] pins,
                                    input logic [PORT_WIDTH-1:0] en);
    port_low = |(~pins & en);
  endfunction : port_low

  logic [7:0] option_r;
  logic [7:0] polarity_r;
  logic [4:0] port_sync;
  logic aw_held_r;
  logic w_held_r;
  logic [9:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  core_mode_t mode_r;
  core_mode_t prev_mode_r;
  logic [PC_WIDTH-1:0] pc_stack_r [STACK_DEPTH];
  logic [1:0] flag_stack_r [STACK_DEPTH];
  logic [PTR_W-1:0] sp_r;
  logic take_r;
  logic [2:0] src_r;
  logic [PC_WIDTH-1:0] vec_r;
  logic ret_r;
  logic [PC_WIDTH-1:0] ret_pc_r;
  logic [1:0] ret_flags_r;

  wire src1_level_edge_sel = option_r[OPT_LEVEL_BIT];
  wire src2_edge_polarity = option_r[OPT_EDGE_BIT];
  wire global_irq_enable = option_r[OPT_ENABLE_BIT];

  // Raw port lines: low when any enabled pin is low
  wire [4:0] port_raw = {
    ~port_low(port_e_pins_in, port_e_irq_en_in),
    ~port_low(port_d_pins_in, port_d_irq_en_in),
    ~port_low(port_c_pins_in, port_c_irq_en_in),
    ~port_low(port_a_pins_in, port_a_irq_en_in),
    ~port_low(port_b_pins_in, port_b_irq_en_in)};

  // Pins pass two flops before any edge detection
  pin_sync #(.WIDTH(5)) u_sync ( // R21
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in(port_raw),
    .sync_out(port_sync)
  );

  // Active-high requests; polarity bit flips the sense
  wire act_a = ~port_sync[0 + POL_PORTA_BIT] ^ polarity_r[POL_PORTA_BIT]; // R12
  wire act_e = ~port_sync[POL_PORTE_BIT] ^ polarity_r[POL_PORTE_BIT]; // R16
  wire act_c = ~port_sync[POL_PORTC_BIT] ^ polarity_r[POL_PORTC_BIT]; // R14
  // Edge select adds a second inversion for source 2
  wire act_b = ~port_sync[POL_PORTB_BIT] ^ polarity_r[POL_PORTB_BIT]
               ^ src2_edge_polarity; // R05 R15
  wire act_d = ~port_sync[POL_PORTD_BIT] ^ polarity_r[POL_PORTD_BIT]
               ^ src2_edge_polarity; // R15

  wire ack0 = take_r && src_r == 3'd0;
  wire ack1 = take_r && src_r == 3'd1;
  wire ack2 = take_r && src_r == 3'd2;
  logic req0;
  logic req1a;
  logic req1e;
  logic req2b;
  logic req2d;

  // Source 0 latched, cleared as its routine begins
  edge_latch u_src0 (.mclk_in(mclk_in), .rst_n_in(rst_n_in), // R20
    .line_in(act_c), .level_mode_in(1'b0), .ack_in(ack0), .req_out(req0));
  // Source 1: level or edge chosen by option bit
  edge_latch u_src1a (.mclk_in(mclk_in), .rst_n_in(rst_n_in), // R04
    .line_in(act_a), .level_mode_in(src1_level_edge_sel), .ack_in(ack1),
    .req_out(req1a));
  edge_latch u_src1e (.mclk_in(mclk_in), .rst_n_in(rst_n_in), // R17
    .line_in(act_e), .level_mode_in(src1_level_edge_sel), .ack_in(ack1),
    .req_out(req1e));
  edge_latch u_src2b (.mclk_in(mclk_in), .rst_n_in(rst_n_in), // R17
    .line_in(act_b), .level_mode_in(1'b0), .ack_in(ack2), .req_out(req2b));
  edge_latch u_src2d (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .line_in(act_d), .level_mode_in(1'b0), .ack_in(ack2), .req_out(req2d));

  // Peripheral events gated by their own enables; levels, never stored
  wire src4 = (src4_events_in.timer_overflow_flag
               & src4_events_in.timer_irq_enable)
            | (src4_events_in.conversion_done_flag
               & src4_events_in.converter_irq_enable)
            | (src4_events_in.byte_received_flag
               & src4_events_in.receive_irq_enable)
            | (src4_events_in.byte_sent_flag
               & src4_events_in.transmit_irq_enable); // R09
  wire src3 = (src3_events_in.reload_timer_overflow_flag
               & src3_events_in.reload_overflow_irq_enable)
            | (src3_events_in.capture_one_flag
               & src3_events_in.capture_one_irq_enable)
            | (src3_events_in.capture_two_flag
               & src3_events_in.capture_two_irq_enable)
            | (src3_events_in.compare_zero_flag
               & src3_events_in.compare_zero_irq_enable)
            | (src3_events_in.compare_match_flag
               & src3_events_in.compare_match_irq_enable); // R10

  wire src1 = req1a | req1e | spi_irq_in;
  wire src2 = req2b | req2d;
  // Maskable sources off unless global enable set
  wire [4:1] mreq = {src4, src3, src2, src1} & {4{global_irq_enable}}; // R06
  // Non-maskable pre-empts anything except itself
  wire nmi_ok = req0 && mode_r != MODE_NMI;
  // Maskable only from normal mode, no nesting
  wire mask_ok = |mreq && mode_r == MODE_NORMAL; // R19
  wire stack_full = sp_r == PTR_W'(STACK_DEPTH);
  // A return executed by the core with a non-empty stack is never dropped, or the stack skews
  wire do_ret = core_in.return_from_irq_instr && core_in.instr_end
                && sp_r != '0;
  // Sampled only at an instruction boundary; a return there goes first
  wire take_now = core_in.instr_end && !take_r && !stack_full && !do_ret
                  && (nmi_ok || mask_ok); // R18
  wire [2:0] pick = nmi_ok ? 3'd0 : mreq[1] ? 3'd1 : mreq[2] ? 3'd2 :
                    mreq[3] ? 3'd3 : 3'd4; // R19
  wire [PC_WIDTH-1:0] pick_vec = pick == 3'd0 ? VEC_SRC0 :
                                 pick == 3'd1 ? VEC_SRC1 :
                                 pick == 3'd2 ? VEC_SRC2 :
                                 pick == 3'd3 ? VEC_SRC3 : VEC_SRC4;
  wire [PTR_W-1:0] top = sp_r - PTR_W'(1);

  // Vectoring, context stack and mode tracking
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      take_r <= 1'b0;
      src_r <= 3'd0;
      vec_r <= '0;
      ret_r <= 1'b0;
      ret_pc_r <= '0;
      ret_flags_r <= 2'b00;
      sp_r <= '0;
      mode_r <= MODE_NORMAL;
      prev_mode_r <= MODE_NORMAL;
    end else begin
      take_r <= take_now;
      ret_r <= do_ret;
      if (take_now) begin
        src_r <= pick;
        vec_r <= pick_vec;
        sp_r <= sp_r + PTR_W'(1);
        prev_mode_r <= mode_r;
        mode_r <= pick == 3'd0 ? MODE_NMI : MODE_IRQ;
      end else if (do_ret) begin
        ret_pc_r <= pc_stack_r[top]; // R01
        ret_flags_r <= flag_stack_r[top]; // R01
        sp_r <= top;
        mode_r <= prev_mode_r;
        prev_mode_r <= MODE_NORMAL;
      end
    end
  end

  // Stack store has no reset; guarded by the pointer
  always_ff @(posedge mclk_in) begin
    if (take_now) begin
      pc_stack_r[sp_r] <= core_pc_in;
      flag_stack_r[sp_r] <= core_flags_in;
    end
  end

  // Wake needs global enable, even for the non-maskable line
  assign wake_out = core_in.in_stop_wait && global_irq_enable
                    && (req0 || |mreq); // R07
  assign take_irq_out = take_r;
  assign irq_source_out = src_r;
  assign vector_out = vec_r;
  assign irq_ret_out = ret_r;
  assign return_pc_out = ret_pc_r;
  assign restore_flags_out = ret_flags_r;
  assign core_mode_out = mode_r;

  // AXI write: address and data latched in either order
  wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
  wire wr_opt = awaddr_r == OPTION_ADDR;
  wire wr_pol = awaddr_r == POLARITY_ADDR;
  wire wr_known = wr_opt || wr_pol || awaddr_r == CORE_STATUS_ADDR;
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[9:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Register file; only whole-byte writes, unused bits dropped
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      option_r <= OPTION_RESET; // R03
      polarity_r <= POLARITY_RESET; // R13
    end else if (wr_fire && wstrb_r[0]) begin
      if (wr_opt) begin
        option_r <= wdata_r[7:0] & OPTION_WMASK; // R08
      end
      if (wr_pol) begin
        polarity_r <= wdata_r[7:0] & POLARITY_WMASK; // R11
      end
    end
  end

  // AXI read; option register gives zero, its used bits read back via the status register
  wire [9:0] raddr = {s_axi_araddr[9:2], 2'b00};
  wire [31:0] status_word = {21'd0, sp_r[2:0] & 3'(STACK_DEPTH > 0 ? 7 : 0),
                             mode_r, 2'b00, global_irq_enable,
                             src1_level_edge_sel, src2_edge_polarity};
  wire [31:0] rd_value = raddr == POLARITY_ADDR ? {24'd0, polarity_r} :
                         raddr == CORE_STATUS_ADDR ? status_word :
                         32'd0; // R02
  wire rd_known = raddr == POLARITY_ADDR || raddr == OPTION_ADDR
                  || raddr == CORE_STATUS_ADDR;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_value;
      rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule : irq_option_polarity_ctrl

// ---- core_model.sv ----
// Behavioural processor core facing the controller's core side
`timescale 1ns/1ps
module core_model (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic sleep_in,
  input wire logic take_irq_in,
  output irq_ctrl_pkg::core_req_t core_out
);
  import irq_ctrl_pkg::*;
  logic [1:0] cnt_r;
  logic [3:0] owe_r;
  // Boundary every fourth cycle; a sleeping core runs no instructions
  wire bound = (cnt_r == 2'h2) && !sleep_in;
  wire ret = bound && (owe_r != 4'h0) && !take_irq_in;
  // Each taken request owes one return, issued at a later boundary
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 2'h0;
      owe_r <= 4'h0;
      core_out <= '0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      owe_r <= owe_r + {3'h0, take_irq_in} - {3'h0, ret};
      core_out <= '{bound, ret, sleep_in};
    end
  end
endmodule : core_model

// ---- irq_ctrl_assertions.sv ----
// Concurrent checks on the controller's core and bus ports
`timescale 1ns/1ps
module irq_ctrl_assertions #(
  parameter int PC_WIDTH = 12
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire irq_ctrl_pkg::core_req_t core_in,
  input wire logic take_irq_out,
  input wire logic [2:0] irq_source_out,
  input wire logic [PC_WIDTH-1:0] vector_out,
  input wire logic irq_ret_out,
  input wire logic [2:0] core_mode_out,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  import irq_ctrl_pkg::*;
  // One clock domain, so clock and reset are given once
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_take_at_boundary: assert property (
    take_irq_out |-> $past(core_in.instr_end))
    else $error("take without instruction boundary");
  a_take_single: assert property (
    take_irq_out |=> !take_irq_out)
    else $error("take pulse longer than one cycle");
  a_vector_map: assert property (
    take_irq_out |-> vector_out == (irq_source_out == 3'h0 ? 12'hFFC :
      12'hFF8 - {8'h00, irq_source_out, 1'b0}))
    else $error("vector does not match source");
  a_no_preempt: assert property (
    take_irq_out && irq_source_out != 3'h0 |-> $past(core_mode_out) == MODE_NORMAL)
    else $error("maskable taken outside normal mode");
  a_nmi_mode: assert property (
    take_irq_out && irq_source_out == 3'h0 |-> core_mode_out == MODE_NMI)
    else $error("nmi take without nmi mode");
  a_ret_cause: assert property (
    irq_ret_out |-> $past(core_in.return_from_irq_instr && core_in.instr_end))
    else $error("return pulse without return instruction");
  a_mode_onehot: assert property (
    $onehot(core_mode_out))
    else $error("mode not one-hot");
  a_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule : irq_ctrl_assertions

bind irq_option_polarity_ctrl irq_ctrl_assertions #(.PC_WIDTH(PC_WIDTH)) chk (
  .mclk_in, .rst_n_in, .core_in, .take_irq_out, .irq_source_out,
  .vector_out, .irq_ret_out, .core_mode_out, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp);

// ---- tb.sv ----
// Self-checking bench for the interrupt option and polarity controller
`timescale 1ns/1ps
module tb;
  import irq_ctrl_pkg::*;
  logic mclk_in = 0, rst_n_in = 0, sleep = 0, loose = 1;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, spi_irq_in = 0;
  logic [31:0] s_axi_wdata = '0, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] pins [5] = '{default: 8'hFF};
  logic [7:0] en = 8'h01;
  src4_events_t src4_events_in = '0;
  src3_events_t src3_events_in = '0;
  core_req_t core_in;
  logic [11:0] core_pc_in = '0, pc_d;
  logic [1:0] core_flags_in = '0, fl_d, r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, restore_flags_out;
  wire [31:0] s_axi_rdata;
  wire take_irq_out, irq_ret_out, wake_out;
  wire [2:0] irq_source_out, core_mode_out;
  wire [11:0] vector_out, return_pc_out;
  int err_count = 0, cmp_count = 0, tk_count = 0, cyc = 0;
  int exp_q[$], stk[$];

  always #10 mclk_in = ~mclk_in;

  irq_option_polarity_ctrl uut (.*, .port_b_pins_in(pins[0]),
    .port_a_pins_in(pins[1]), .port_c_pins_in(pins[2]),
    .port_d_pins_in(pins[3]), .port_e_pins_in(pins[4]),
    .port_a_irq_en_in(en), .port_b_irq_en_in(en), .port_c_irq_en_in(en),
    .port_d_irq_en_in(en), .port_e_irq_en_in(en));
  core_model core (.mclk_in, .rst_n_in, .sleep_in(sleep),
    .take_irq_in(take_irq_out), .core_out(core_in));

  function automatic logic [11:0] vec_of(input int s);
    return s == 0 ? 12'hFFC : 12'hFF8 - 12'(2 * s);
  endfunction : vec_of

  task automatic cmp(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic chk_reg(input logic [31:0] got, exp);
    cmp(got, exp, "register");
  endtask : chk_reg
  task automatic chk_core(input logic [31:0] got, exp);
    cmp(got, exp, "core");
  endtask : chk_core

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Reference model: expected source order and a return stack
  always @(posedge mclk_in) begin : mon
    int e;
    cyc++;
    if (take_irq_out === 1'b1) begin
      tk_count++;
      stk.push_back({fl_d, pc_d});
      if (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        chk_core(irq_source_out, e);
        chk_core(vector_out, vec_of(e));
      end else if (!loose) begin
        err_count++;
        $display("[ERR] %0t unexpected take", $time);
      end
    end
    if (irq_ret_out === 1'b1 && stk.size() > 0) begin
      e = stk.pop_back();
      chk_core(return_pc_out, e[11:0]);
      chk_core(restore_flags_out, e[13:12]);
    end
    pc_d = core_pc_in;
    fl_d = core_flags_in;
    core_pc_in <= 12'($urandom);
    core_flags_in <= 2'($urandom);
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic axi_wr(input logic [9:0] a, input logic [7:0] v);
    bit aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge mclk_in);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge mclk_in); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  // Ready raised a cycle late so the held answer is exercised
  task automatic axi_rd(input logic [9:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk_in); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge mclk_in);
    s_axi_rready <= 1'b1;
    do @(posedge mclk_in); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic quiet(input int n);
    int t;
    t = tk_count;
    repeat (n) @(posedge mclk_in);
    chk_core(tk_count, t);
  endtask : quiet

  task automatic expect_take(input int src);
    int t;
    t = tk_count;
    exp_q.push_back(src);
    repeat (300) begin
      @(posedge mclk_in);
      #1;
      if (tk_count != t) break;
    end
    @(posedge mclk_in);
    chk_core(tk_count, t + 1);
    if (tk_count == t) exp_q.delete();
  endtask : expect_take

  task automatic settle(input logic [7:0] opt, pol);
    loose <= 1'b1;
    axi_wr(OPTION_ADDR, opt);
    axi_wr(POLARITY_ADDR, pol);
    repeat (30) @(posedge mclk_in);
    loose <= 1'b0;
  endtask : settle

  initial begin
    void'($urandom(32'h4922_a18e));
    en = 8'h01 | 8'($urandom);
    repeat (10) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    axi_rd(CORE_STATUS_ADDR);
    chk_reg(d, 32'h0000_0020);
    axi_rd(POLARITY_ADDR);
    chk_reg(d, 32'h0000_0000);
    axi_wr(POLARITY_ADDR, 8'hFF);
    axi_rd(POLARITY_ADDR);
    chk_reg(d, 32'h0000_001F);
    axi_rd(10'h100);
    chk_reg(r, RESP_SLVERR);
    // Enabled settle drains edges left by the polarity write test
    settle(8'h10, 8'h00);
    axi_rd(OPTION_ADDR);
    chk_reg(d, 32'h0000_0000);
    axi_wr(OPTION_ADDR, 8'h8F);
    // Timer request pending while only unused option bits were written
    src4_events_in <= 8'hC0;
    quiet(16);
    sleep <= 1'b1;
    pins[2] <= 8'hFE;
    repeat (10) @(posedge mclk_in);
    chk_core(wake_out, 0);
    sleep <= 1'b0;
    expect_take(0);
    pins[2] <= 8'hFF;
    axi_wr(OPTION_ADDR, 8'h10);
    expect_take(4);
    src4_events_in <= '0;
    // Each event alone, first without its enable
    for (int i = 0; i < 9; i++) begin
      if (i < 5) src3_events_in <= 10'h002 << (2 * i);
      else src4_events_in <= 8'h02 << (2 * (i - 5));
      quiet(12);
      if (i < 5) src3_events_in <= 10'h003 << (2 * i);
      else src4_events_in <= 8'h03 << (2 * (i - 5));
      expect_take(i < 5 ? 3 : 4);
      src3_events_in <= '0;
      src4_events_in <= '0;
    end
    sleep <= 1'b1;
    src3_events_in <= '1;
    src4_events_in <= '1;
    pins[4] <= 8'hFE;
    repeat (10) @(posedge mclk_in);
    chk_core(wake_out, 1);
    sleep <= 1'b0;
    expect_take(1);
    expect_take(3);
    src3_events_in <= '0;
    expect_take(4);
    src4_events_in <= '0;
    // Every port under both senses, both edge selections
    for (int k = 0; k < 20; k++) begin
      int j, p, eb, s;
      bit rise;
      j = k % 5;
      p = (k / 5) % 2;
      eb = k / 10;
      s = (j == 2) ? 0 : (j == 0 || j == 3) ? 2 : 1;
      rise = 1'(p ^ (eb & int'(j == 0 || j == 3)));
      pins[j] <= rise ? 8'hFE : 8'hFF;
      settle(8'(16 + 32 * eb), 8'(p << j));
      quiet(12);
      pins[j] <= rise ? 8'hFF : 8'hFE;
      expect_take(s);
    end
    pins <= '{default: 8'hFF};
    settle(8'h50, 8'h00);
    sleep <= 1'b1;
    pins[1] <= 8'hFE;
    repeat (8) @(posedge mclk_in);
    pins[1] <= 8'hFF;
    repeat (8) @(posedge mclk_in);
    sleep <= 1'b0;
    quiet(16);
    pins[1] <= 8'hFE;
    expect_take(1);
    pins[1] <= 8'hFF;
    repeat (20) @(posedge mclk_in);
    give_verdict();
  end
endmodule : tb
